// File: hdl/tcac_pkg.sv
// Constants, types and register map of the conversion and alert block
package tcac_pkg;

	// ==========================================================
	// Bus and register map (index; byte address is index * 4)
	localparam int AXI_ADDR_W = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [5:0] IDX_TEMP_MSB = 6'h00;
	localparam logic [5:0] IDX_TEMP_LSB = 6'h01;
	localparam logic [5:0] IDX_STATUS = 6'h02;
	localparam logic [5:0] IDX_CONFIG = 6'h03;
	localparam logic [5:0] IDX_HIGH_MSB = 6'h04;
	localparam logic [5:0] IDX_HIGH_LSB = 6'h05;
	localparam logic [5:0] IDX_LOW_MSB = 6'h06;
	localparam logic [5:0] IDX_LOW_LSB = 6'h07;
	localparam logic [5:0] IDX_CRIT_MSB = 6'h08;
	localparam logic [5:0] IDX_CRIT_LSB = 6'h09;
	localparam logic [5:0] IDX_HYST = 6'h0A;
	localparam logic [5:0] IDX_ID = 6'h0B;

	// ==========================================================
	// Reset values
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] HIGH_RST = 16'h2000;
	localparam logic [15:0] LOW_RST = 16'h0500;
	localparam logic [15:0] CRIT_RST = 16'h4980;
	localparam logic [3:0] HYST_RST = 4'h5;
	localparam logic [15:0] RESULT_RST = 16'h0000;

	// ==========================================================
	// Field positions
	localparam int HYST_SHIFT = 7;
	localparam int FLAG_CRIT_BIT = 0;
	localparam int FLAG_HIGH_BIT = 1;
	localparam int FLAG_LOW_BIT = 2;
	localparam int STAT_LOW_BIT = 4;
	localparam int STAT_HIGH_BIT = 5;
	localparam int STAT_CRIT_BIT = 6;
	localparam int STAT_BUSY_BIT = 7;
	localparam logic [2:0] FAULT_CNT_MAX = 3'h4;

	// Operation mode field (bit 6, bit 5)
	localparam logic [1:0] MODE_CONT = 2'h0;
	localparam logic [1:0] MODE_1SPS = 2'h1;
	localparam logic [1:0] MODE_ONESHOT = 2'h2;
	localparam logic [1:0] MODE_SHUTDN = 2'h3;

	// ==========================================================
	// Timing
	localparam longint CLK_HZ = 100000000;
	localparam longint CYC_PER_MS = CLK_HZ / 1000;
	localparam longint CONV_NORMAL_MS = 240;
	localparam longint CONV_FAST_MS = 6;
	localparam longint CONV_1SPS_MS = 60;
	localparam longint IDLE_1SPS_MS = 940;
	localparam longint WAKE_MS = 1;
	localparam int unsigned CONV_NORMAL_CYC = int'(CONV_NORMAL_MS * CYC_PER_MS);
	localparam int unsigned CONV_FAST_CYC = int'(CONV_FAST_MS * CYC_PER_MS);
	localparam int unsigned CONV_1SPS_CYC = int'(CONV_1SPS_MS * CYC_PER_MS);
	localparam int unsigned IDLE_1SPS_CYC = int'(IDLE_1SPS_MS * CYC_PER_MS);
	localparam int unsigned WAKE_CYC = int'(WAKE_MS * CYC_PER_MS);

	// ==========================================================
	// Types
	typedef enum logic [1:0] {ST_WAKE, ST_CONV, ST_IDLE, ST_SHUT} tcac_state_t;

	typedef struct packed {
		logic res16;
		logic [1:0] mode;
		logic irq_mode;
		logic lim_pol;
		logic crit_pol;
		logic [1:0] queue;
	} tcac_cfg_t;

endpackage

// File: hdl/tcac_top.sv
// Conversion sequencer, limit comparison and alert pins behind an AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module tcac_top #(
	parameter int unsigned CONV_NORMAL_CYC = tcac_pkg::CONV_NORMAL_CYC,
	parameter int unsigned CONV_FAST_CYC = tcac_pkg::CONV_FAST_CYC,
	parameter int unsigned CONV_1SPS_CYC = tcac_pkg::CONV_1SPS_CYC,
	parameter int unsigned IDLE_1SPS_CYC = tcac_pkg::IDLE_1SPS_CYC,
	parameter int unsigned WAKE_CYC = tcac_pkg::WAKE_CYC,
	// Identity byte; value is arbitrary
	parameter logic [7:0] ID_CODE = 8'hA5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite register slave
	input wire logic [tcac_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tcac_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Modulator result, same clock
	input wire logic [15:0] sensor_temp,
	// Open-drain alert pins
	output logic critical_alert_output,
	output logic critical_alert_output_oe,
	output logic limit_alert_output,
	output logic limit_alert_output_oe
);
	import tcac_pkg::*;

	// ==========================================================
	// Parameter check
	if (CONV_NORMAL_CYC < 1 || CONV_FAST_CYC < 1 || CONV_1SPS_CYC < 1 ||
		IDLE_1SPS_CYC < 1 || WAKE_CYC < 1)
	begin : g_bad_timing
		$error("tcac_top: every timing count must be at least one cycle");
	end

	// ==========================================================
	// Declarations
	tcac_cfg_t cfg;
	tcac_state_t state;
	logic [31:0] timer;
	logic [15:0] result;
	logic [15:0] high_lim;
	logic [15:0] low_lim;
	logic [15:0] crit_lim;
	logic [3:0] hyst;
	logic [2:0] flags;
	logic [2:0] fault_cnt;
	logic lim_band_q;
	logic crit_band_q;
	logic crit_act;
	logic lim_act;
	logic aw_held;
	logic w_held;
	logic [5:0] aw_idx;
	logic [7:0] w_byte;
	logic w_lane0;
	logic wr_fire;
	logic wr_ok;
	logic cfg_wr;
	logic oneshot_start;
	logic ar_fire;
	logic [5:0] ar_idx;
	logic [7:0] rd_byte;
	logic rd_ok;
	logic rd_evt;
	logic conv_done;
	logic [15:0] meas;
	logic [15:0] hyst16;
	logic over_crit;
	logic over_high;
	logic under_low;
	logic fault;
	logic qual;
	logic lim_band;
	logic crit_band;

	// Reload value for a conversion in the given mode
	function automatic logic [31:0] conv_len(input logic [1:0] m);
		conv_len = (m == MODE_1SPS) ? 32'(CONV_1SPS_CYC - 1) :
			32'(CONV_NORMAL_CYC - 1);
	endfunction

	// ==========================================================
	// AXI4-Lite write channel
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign cfg_wr = wr_fire && w_lane0 && aw_idx == IDX_CONFIG;
	assign oneshot_start = cfg_wr && w_byte[6:5] == MODE_ONESHOT;

	always_comb
	begin
		case (aw_idx)
			IDX_CONFIG, IDX_HIGH_MSB, IDX_HIGH_LSB, IDX_LOW_MSB, IDX_LOW_LSB,
			IDX_CRIT_MSB, IDX_CRIT_LSB, IDX_HYST: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= 6'h00;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held)
			begin
				aw_held <= 1'b1;
				aw_idx <= s_axi_awaddr[7:2];
			end
			else if (wr_fire)
				aw_held <= 1'b0;
			if (s_axi_wvalid && !w_held)
			begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			else if (wr_fire)
				w_held <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ==========================================================
	// Writable registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cfg <= tcac_cfg_t'(CFG_RST);
			high_lim <= HIGH_RST;
			low_lim <= LOW_RST;
			crit_lim <= CRIT_RST;
			hyst <= HYST_RST;
		end
		else if (wr_fire && w_lane0)
		begin
			case (aw_idx)
				IDX_CONFIG: cfg <= tcac_cfg_t'(w_byte);
				IDX_HIGH_MSB: high_lim[15:8] <= w_byte;
				IDX_HIGH_LSB: high_lim[7:0] <= w_byte;
				IDX_LOW_MSB: low_lim[15:8] <= w_byte;
				IDX_LOW_LSB: low_lim[7:0] <= w_byte;
				IDX_CRIT_MSB: crit_lim[15:8] <= w_byte;
				IDX_CRIT_LSB: crit_lim[7:0] <= w_byte;
				IDX_HYST: hyst <= w_byte[3:0];
				default: hyst <= hyst;
			endcase
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_fire = s_axi_arvalid && !s_axi_rvalid;
	assign ar_idx = s_axi_araddr[7:2];
	assign rd_evt = ar_fire && rd_ok;

	always_comb
	begin
		rd_byte = 8'h00;
		rd_ok = 1'b1;
		case (ar_idx)
			IDX_TEMP_MSB: rd_byte = result[15:8];
			IDX_TEMP_LSB: rd_byte = result[7:0];
			IDX_STATUS:
			begin
				rd_byte[STAT_BUSY_BIT] = state == ST_CONV;
				rd_byte[STAT_CRIT_BIT] = flags[FLAG_CRIT_BIT];
				rd_byte[STAT_HIGH_BIT] = flags[FLAG_HIGH_BIT];
				rd_byte[STAT_LOW_BIT] = flags[FLAG_LOW_BIT];
			end
			IDX_CONFIG: rd_byte = cfg;
			IDX_HIGH_MSB: rd_byte = high_lim[15:8];
			IDX_HIGH_LSB: rd_byte = high_lim[7:0];
			IDX_LOW_MSB: rd_byte = low_lim[15:8];
			IDX_LOW_LSB: rd_byte = low_lim[7:0];
			IDX_CRIT_MSB: rd_byte = crit_lim[15:8];
			IDX_CRIT_LSB: rd_byte = crit_lim[7:0];
			IDX_HYST: rd_byte = {4'h0, hyst};
			IDX_ID: rd_byte = ID_CODE;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (ar_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==========================================================
	// Conversion sequencer, timed from clk alone
	assign conv_done = state == ST_CONV && timer == 32'h0 && !oneshot_start &&
		cfg.mode != MODE_SHUTDN;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= ST_CONV;
			timer <= 32'(CONV_FAST_CYC - 1);
		end
		else if (oneshot_start)
		begin
			state <= ST_CONV;
			timer <= 32'(CONV_NORMAL_CYC - 1);
		end
		else
		begin
			case (state)
				ST_CONV:
					if (cfg.mode == MODE_SHUTDN)
						state <= ST_SHUT;
					else if (timer != 32'h0)
						timer <= timer - 32'h1;
					else if (cfg.mode == MODE_CONT)
						timer <= 32'(CONV_NORMAL_CYC - 1);
					else if (cfg.mode == MODE_1SPS)
					begin
						state <= ST_IDLE;
						timer <= 32'(IDLE_1SPS_CYC - 1);
					end
					else
						state <= ST_SHUT;
				ST_IDLE:
					if (cfg.mode == MODE_SHUTDN || cfg.mode == MODE_ONESHOT)
						state <= ST_SHUT;
					else if (cfg.mode == MODE_CONT)
					begin
						state <= ST_CONV;
						timer <= 32'(CONV_NORMAL_CYC - 1);
					end
					else if (timer != 32'h0)
						timer <= timer - 32'h1;
					else
					begin
						state <= ST_CONV;
						timer <= 32'(CONV_1SPS_CYC - 1);
					end
				ST_SHUT:
					if (cfg.mode == MODE_CONT || cfg.mode == MODE_1SPS)
					begin
						state <= ST_WAKE;
						timer <= 32'(WAKE_CYC - 1);
					end
				ST_WAKE:
					if (cfg.mode == MODE_SHUTDN || cfg.mode == MODE_ONESHOT)
						state <= ST_SHUT;
					else if (timer != 32'h0)
						timer <= timer - 32'h1;
					else
					begin
						state <= ST_CONV;
						timer <= conv_len(cfg.mode);
					end
				default: state <= ST_SHUT;
			endcase
		end
	end

	// ==========================================================
	// Limit comparison
	always_comb
	begin
		meas = cfg.res16 ? sensor_temp : {sensor_temp[15:3], 3'h0};
		hyst16 = 16'({hyst, 7'h00});
		over_crit = $signed(meas) > $signed(crit_lim);
		over_high = $signed(meas) > $signed(high_lim);
		under_low = $signed(meas) < $signed(low_lim);
		fault = over_crit || over_high || under_low;
		lim_band = $signed(meas) < $signed(high_lim - hyst16) &&
			$signed(meas) > $signed(low_lim + hyst16);
		crit_band = $signed(meas) < $signed(crit_lim - hyst16);
	end

	// Fault queue: field value n needs n+1 consecutive faults
	assign qual = conv_done && fault && fault_cnt >= {1'b0, cfg.queue};

	// ==========================================================
	// Result store and fault counter
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			result <= RESULT_RST;
			flags <= 3'h0;
			fault_cnt <= 3'h0;
			lim_band_q <= 1'b0;
			crit_band_q <= 1'b0;
		end
		else if (conv_done)
		begin
			result <= cfg.res16 ? meas :
				{meas[15:3], under_low, over_high, over_crit};
			flags <= {under_low, over_high, over_crit};
			lim_band_q <= lim_band;
			crit_band_q <= crit_band;
			if (!fault)
				fault_cnt <= 3'h0;
			else if (fault_cnt < FAULT_CNT_MAX)
				fault_cnt <= fault_cnt + 3'h1;
		end
	end

	// ==========================================================
	// Alert state; a set in the same cycle as a clear wins
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			crit_act <= 1'b0;
		else if (qual && over_crit)
			crit_act <= 1'b1;
		else if (cfg.irq_mode ? rd_evt : ((conv_done && crit_band) ||
			(oneshot_start && crit_band_q)))
			crit_act <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			lim_act <= 1'b0;
		else if (qual && (over_high || under_low))
			lim_act <= 1'b1;
		else if (cfg.irq_mode ? rd_evt : ((conv_done && lim_band) ||
			(oneshot_start && lim_band_q)))
			lim_act <= 1'b0;
	end

	// ==========================================================
	// Open-drain pins: enable pulls low when the level must be low
	assign critical_alert_output = 1'b0;
	assign limit_alert_output = 1'b0;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			critical_alert_output_oe <= 1'b0;
			limit_alert_output_oe <= 1'b0;
		end
		else
		begin
			critical_alert_output_oe <= crit_act ? !cfg.crit_pol : cfg.crit_pol;
			limit_alert_output_oe <= lim_act ? !cfg.lim_pol : cfg.lim_pol;
		end
	end

endmodule // tcac_top

// File: sim/tb_tcac_top.sv
// Self-checking bench for the conversion and alert block
`timescale 1ns/1ns
module tb_tcac_top;
	import tcac_pkg::*;
	localparam int NC = 200;
	localparam int WK = 10;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr, araddr, d;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [15:0] sensor_temp = 16'h2180;
	logic crit, crit_oe, lim, lim_oe;
	int mismatches = 0;
	int tests_run = 0;
	always #5 clk = ~clk;
	tcac_top #(.CONV_NORMAL_CYC(NC), .CONV_FAST_CYC(20),
		.CONV_1SPS_CYC(50), .IDLE_1SPS_CYC(100), .WAKE_CYC(WK)) i_tcac_top (
		.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sensor_temp(sensor_temp),
		.critical_alert_output(crit), .critical_alert_output_oe(crit_oe),
		.limit_alert_output(lim), .limit_alert_output_oe(lim_oe));
	tcac_host i_tcac_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	// ==========================================================
	// Helpers
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [5:0] i, input logic [7:0] e);
		i_tcac_host.rd(i, d, r);
		chk(d, e);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic end_sim();
		mismatches += i_tcac_host.timeouts;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_fast();
		wt(10);
		rdc(IDX_TEMP_MSB, 8'h00);
		wt(15);
		rdc(IDX_TEMP_MSB, 8'h21);
		rdc(IDX_TEMP_LSB, 8'h82);
		chk({7'h0, lim_oe}, 8'h01);
		chk({7'h0, crit_oe}, 8'h00);
	endtask
	task automatic t_regs();
		rdc(IDX_CONFIG, 8'h00);
		rdc(IDX_HIGH_MSB, 8'h20);
		rdc(IDX_CRIT_MSB, 8'h49);
		rdc(IDX_CRIT_LSB, 8'h80);
		rdc(IDX_LOW_MSB, 8'h05);
		rdc(IDX_HYST, 8'h05);
		i_tcac_host.rd(6'h0C, d, r);
		chk({6'h0, r}, {6'h0, RESP_SLVERR});
		i_tcac_host.wr(IDX_TEMP_MSB, 8'hFF, r);
		chk({6'h0, r}, {6'h0, RESP_SLVERR});
		rdc(IDX_TEMP_MSB, 8'h21);
	endtask
	task automatic t_crit();
		sensor_temp <= 16'h4A00;
		wt(NC + 10);
		chk({7'h0, crit_oe}, 8'h01);
		rdc(IDX_TEMP_LSB, 8'h03);
		sensor_temp <= 16'h1900;
		wt(NC + 10);
		chk({7'h0, crit_oe}, 8'h00);
		chk({7'h0, lim_oe}, 8'h00);
		rdc(IDX_TEMP_MSB, 8'h19);
	endtask
	task automatic t_oneshot();
		sensor_temp <= 16'h1907;
		i_tcac_host.wr(IDX_CONFIG, 8'hC0, r);
		wt(NC + 5);
		rdc(IDX_TEMP_LSB, 8'h07);
		sensor_temp <= 16'h1000;
		wt(2 * NC);
		rdc(IDX_TEMP_MSB, 8'h19);
		rdc(IDX_TEMP_LSB, 8'h07);
	endtask
	task automatic t_wake();
		i_tcac_host.wr(IDX_CONFIG, 8'h00, r);
		wt(NC - 20);
		rdc(IDX_TEMP_MSB, 8'h19);
		wt(40);
		rdc(IDX_TEMP_MSB, 8'h10);
		sensor_temp <= 16'h1100;
		wt(NC);
		rdc(IDX_TEMP_MSB, 8'h11);
	endtask
	task automatic t_queue();
		i_tcac_host.wr(IDX_CONFIG, 8'h63, r);
		sensor_temp <= 16'h2100;
		i_tcac_host.wr(IDX_CONFIG, 8'h03, r);
		wt(WK + 3 * NC + 20);
		chk({7'h0, lim_oe}, 8'h00);
		wt(NC);
		chk({7'h0, lim_oe}, 8'h01);
	endtask
	task automatic t_irq();
		i_tcac_host.wr(IDX_CONFIG, 8'h10, r);
		i_tcac_host.rd(IDX_HYST, d, r);
		wt(2);
		chk({7'h0, lim_oe}, 8'h00);
		wt(NC + 10);
		chk({7'h0, lim_oe}, 8'h01);
	endtask
	task automatic t_pol();
		sensor_temp <= 16'h1900;
		i_tcac_host.wr(IDX_CONFIG, 8'h0C, r);
		wt(NC + 10);
		chk({7'h0, crit_oe}, 8'h01);
		chk({7'h0, lim_oe}, 8'h01);
		chk({6'h0, crit, lim}, 8'h00);
	endtask
	task automatic t_1sps();
		int n;
		n = 0;
		i_tcac_host.wr(IDX_CONFIG, 8'h20, r);
		sensor_temp <= 16'h1200;
		d = 8'h00;
		while (n < 2 * NC && d !== 8'h12)
		begin
			i_tcac_host.rd(IDX_TEMP_MSB, d, r);
			n++;
		end
		chk(d, 8'h12);
		if (d !== 8'h12)
			end_sim();
		else
		begin
			sensor_temp <= 16'h1300;
			wt(60);
			rdc(IDX_STATUS, 8'h00);
			wt(60);
			rdc(IDX_STATUS, 8'h80);
			rdc(IDX_TEMP_MSB, 8'h12);
			wt(30);
			rdc(IDX_TEMP_MSB, 8'h13);
		end
	endtask
	initial
	begin
		wt(20);
		rst_n <= 1'b1;
		t_fast();
		t_regs();
		t_crit();
		t_oneshot();
		t_wake();
		t_queue();
		t_irq();
		t_pol();
		t_1sps();
		end_sim();
	end
	// Bus wait ran out: close the run at once
	always @(posedge clk)
		if (i_tcac_host.timeouts != 0)
			end_sim();
endmodule // tb_tcac_top

// File: sim/tcac_host.sv
// Register bus host model issuing AXI4-Lite cycles
`timescale 1ns/1ns
module tcac_host (
	// Clock
	input wire logic clk,
	// Write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	int timeouts = 0;
	initial
	begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	task automatic wr(input logic [5:0] i, input logic [7:0] v,
		output logic [1:0] r);
		int n;
		n = 0;
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 50 && !bvalid)
		begin
			@(posedge clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		if (!bvalid)
			timeouts++;
		r = bresp;
		bready <= 1'b0;
		wdata <= ~wdata;
		@(posedge clk);
	endtask
	task automatic rd(input logic [5:0] i, output logic [7:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		araddr <= {i, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 50 && !rvalid)
		begin
			@(posedge clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		if (!rvalid)
			timeouts++;
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
endmodule // tcac_host

// File: sim/tcac_monitor.sv
// Concurrent checks on the register bus and alert pins
`timescale 1ns/1ns
module tcac_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Alert pins
	input wire logic critical_alert_output,
	input wire logic critical_alert_output_oe,
	input wire logic limit_alert_output,
	input wire logic limit_alert_output_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Read channel
	chk_rd_latency: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rd_release: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	chk_rd_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	// ==========================================================
	// Write channel
	chk_wr_latency: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	chk_wr_release: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not released");
	chk_wr_blocked: assert property ($rose(s_axi_bvalid) |->
		$past(s_axi_awready) == 1'b0 && $past(s_axi_wready) == 1'b0)
		else $error("write answered before both channels held");
	// ==========================================================
	// Alert pins
	chk_alert_idle: assert property ($rose(rst_n) |->
		!critical_alert_output_oe && !limit_alert_output_oe)
		else $error("alert driven after reset");
	chk_pin_low: assert property (
		critical_alert_output == 1'b0 && limit_alert_output == 1'b0)
		else $error("open-drain data not low");
	cover property ($rose(limit_alert_output_oe));
	cover property ($rose(critical_alert_output_oe));
	cover property (s_axi_bvalid && s_axi_bready);
endmodule // tcac_monitor

bind tcac_top tcac_monitor i_tcac_monitor (
	.clk(clk), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.critical_alert_output(critical_alert_output),
	.critical_alert_output_oe(critical_alert_output_oe),
	.limit_alert_output(limit_alert_output),
	.limit_alert_output_oe(limit_alert_output_oe)
);
